// ==== core/mtpd_defines.svh ====
// Constants for the memory test pattern driver
`ifndef MTPD_DEFINES_SVH
`define MTPD_DEFINES_SVH
// Local address layout: bank on top, column words at the bottom
`define MTPD_BANK_W      3
`define MTPD_ROW_W       14
`define MTPD_LCOL_W      8
`define MTPD_ADDR_W      25
`define MTPD_DATA_W      32
`define MTPD_BE_W        4
`define MTPD_BYTE_W      8
`define MTPD_SIZE_W      2
`define MTPD_SIZE_ONE    2'h1
`define MTPD_LOCAL_BURST 2
`define MTPD_IDX_W       16
`define MTPD_TESTS       7
`define MTPD_EN_W        5
// Synchronised enable bits
`define MTPD_EN_SEQ      0
`define MTPD_EN_INC      1
`define MTPD_EN_MSK      2
`define MTPD_EN_ADR      3
`define MTPD_EN_LP       4
// Test numbers, equal to their status bit
`define MTPD_T_SEQ       0
`define MTPD_T_INC       1
`define MTPD_T_MSK       2
`define MTPD_T_ADR       3
`define MTPD_T_PDN       4
`define MTPD_T_SRF       5
`define MTPD_T_APC       6
`define MTPD_T_NONE      7
// Sequential extent: column words, banks, rows as index bit fields
`define MTPD_SEQ_COL_HI  2
`define MTPD_SEQ_BANK_LO 3
`define MTPD_SEQ_BANK_HI 5
`define MTPD_SEQ_ROW_LO  6
`define MTPD_SEQ_ROW_HI  7
`define MTPD_SEQ_COUNT   16'h0100
`define MTPD_INC_COUNT   16'h0008
`define MTPD_MSK_COUNT   16'h0008
`define MTPD_APC_COUNT   16'h0008
// Address pins: index 0 zeros, walking one, walking zero, zeros
`define MTPD_ADR_COUNT   16'h0034
`define MTPD_ADR_ONE_END 16'h0019
`define MTPD_ADR_ZER_END 16'h0032
`define MTPD_APC_BASE    25'h0000100
`define MTPD_ALL_ONES    32'hffffffff
`define MTPD_BYTE_ONES   32'h000000ff
`define MTPD_BE_ALL      4'hf
`define MTPD_BE_ONE      4'h1
`define MTPD_LFSR_SEED   32'h5a5a0001
`define MTPD_TAP_A       31
`define MTPD_TAP_B       21
`define MTPD_TAP_C       1
`define MTPD_TAP_D       0
`endif

// ==== core/mtpd_pkg.sv ====
// Types shared by the memory test pattern driver
package mtpd_pkg;
`include "mtpd_defines.svh"
   typedef logic [`MTPD_ADDR_W-1:0] mtpd_addr_t;
   typedef logic [`MTPD_BANK_W-1:0] mtpd_bank_t;
   typedef logic [`MTPD_ROW_W-1:0]  mtpd_row_t;
   typedef logic [`MTPD_LCOL_W-1:0] mtpd_lcol_t;
   typedef logic [`MTPD_DATA_W-1:0] mtpd_data_t;
   typedef logic [`MTPD_BE_W-1:0]   mtpd_be_t;
   typedef logic [`MTPD_IDX_W-1:0]  mtpd_idx_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0, ST_SEQ_WR = 4'h1, ST_SEQ_RD = 4'h2, ST_INC_WR = 4'h3,
      ST_INC_RD = 4'h4, ST_MSK_CL = 4'h5, ST_MSK_BY = 4'h6, ST_MSK_RD = 4'h7,
      ST_ADR_WR = 4'h8, ST_ADR_RD = 4'h9, ST_PDN    = 4'ha, ST_SRF    = 4'hb,
      ST_APC_WR = 4'hc, ST_APC_RD = 4'hd, ST_DONE   = 4'he
   } mtpd_state_t;

   // One request word as presented to the controller
   typedef struct packed {
      mtpd_addr_t addr;
      mtpd_data_t data;
      mtpd_be_t   be;
   } mtpd_req_t;
endpackage : mtpd_pkg

// ==== core/mtpd_lfsr.sv ====
// Pseudo-random word generator with reload and step
`timescale 1ns/1ns
`include "mtpd_defines.svh"
module mtpd_lfsr
   import mtpd_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic       load,
   input  wire logic       step,
   output mtpd_data_t      value,
   output mtpd_data_t      value_nxt
);
   mtpd_data_t q_r;

   // Load beats step so a restart always begins at the seed
   always_comb begin
      if (load) begin
         value_nxt = `MTPD_LFSR_SEED;
      end else if (step) begin
         value_nxt = {q_r[`MTPD_DATA_W-2:0],
                      q_r[`MTPD_TAP_A] ^ q_r[`MTPD_TAP_B] ^ q_r[`MTPD_TAP_C] ^ q_r[`MTPD_TAP_D]};
      end else begin
         value_nxt = q_r;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r <= `MTPD_LFSR_SEED;
      end else begin
         q_r <= value_nxt;
      end
   end

   assign value = q_r;
endmodule : mtpd_lfsr

// ==== core/mtpd_driver.sv ====
// Self-checking traffic generator on the memory controller local port
`timescale 1ns/1ns
`include "mtpd_defines.svh"
module mtpd_driver
   import mtpd_pkg::*;
(
   input  wire logic                    core_clk,
   input  wire logic                    sys_rst,
   input  wire logic                    seq_test_enable,
   input  wire logic                    incomplete_write_enable,
   input  wire logic                    byte_mask_check_enable,
   input  wire logic                    addr_pin_test_enable,
   input  wire logic                    low_power_option_enable,
   input  wire logic [`MTPD_IDX_W-1:0]  hold_count,
   input  wire logic                    local_ready,
   input  wire logic [`MTPD_DATA_W-1:0] local_rdata,
   input  wire logic                    local_rdata_valid,
   output logic                         local_write_req,
   output logic                         local_read_req,
   output logic [`MTPD_ADDR_W-1:0]      local_address,
   output logic [`MTPD_DATA_W-1:0]      local_wdata,
   output logic [`MTPD_BE_W-1:0]        request_byte_enables,
   output logic [`MTPD_SIZE_W-1:0]      local_size,
   output logic                         local_powerdn_req,
   output logic                         local_self_rfsh_req,
   output logic                         local_autopch_req,
   output logic                         pnf,
   output logic [`MTPD_BE_W-1:0]        pnf_per_byte,
   output logic [`MTPD_TESTS-1:0]       test_status,
   output logic                         test_complete
);
   logic [`MTPD_EN_W-1:0]  en_s1_r, en_s2_r, en_s3_r, en_r;
   mtpd_state_t            state_r, state_nxt;
   mtpd_idx_t              idx_r, idx_nxt, ret_r, ret_nxt;
   mtpd_req_t              req_r;
   logic                   wr_req_r, rd_req_r, wr_acc, rd_acc, chk_valid;
   logic                   gen_load, gen_step, chk_load, chk_step;
   mtpd_data_t             gen_q, gen_nxt, chk_q, exp_data;
   logic                   pdn_r, srf_r, apc_r, pnf_r, done_r;
   logic [`MTPD_BE_W-1:0]  pnf_byte_r;
   logic [`MTPD_TESTS-1:0] status_r;

   function automatic int test_of(input mtpd_state_t st);
      case (st)
         ST_SEQ_WR, ST_SEQ_RD:            test_of = `MTPD_T_SEQ;
         ST_INC_WR, ST_INC_RD:            test_of = `MTPD_T_INC;
         ST_MSK_CL, ST_MSK_BY, ST_MSK_RD: test_of = `MTPD_T_MSK;
         ST_ADR_WR, ST_ADR_RD:            test_of = `MTPD_T_ADR;
         ST_PDN:                          test_of = `MTPD_T_PDN;
         ST_SRF:                          test_of = `MTPD_T_SRF;
         ST_APC_WR, ST_APC_RD:            test_of = `MTPD_T_APC;
         default:                         test_of = `MTPD_T_NONE;
      endcase
   endfunction : test_of

   function automatic logic test_on(input int t, input logic [`MTPD_EN_W-1:0] en);
      case (t)
         `MTPD_T_SEQ: test_on = en[`MTPD_EN_SEQ];
         `MTPD_T_INC: test_on = en[`MTPD_EN_INC] && (`MTPD_LOCAL_BURST == 2);
         `MTPD_T_MSK: test_on = en[`MTPD_EN_MSK];
         `MTPD_T_ADR: test_on = en[`MTPD_EN_ADR];
         `MTPD_T_PDN, `MTPD_T_SRF: test_on = en[`MTPD_EN_LP];
         `MTPD_T_APC: test_on = 1'b1;
         default:     test_on = 1'b0;
      endcase
   endfunction : test_on

   function automatic mtpd_state_t start_of(input int t);
      case (t)
         `MTPD_T_SEQ: start_of = ST_SEQ_WR;
         `MTPD_T_INC: start_of = ST_INC_WR;
         `MTPD_T_MSK: start_of = ST_MSK_CL;
         `MTPD_T_ADR: start_of = ST_ADR_WR;
         `MTPD_T_PDN: start_of = ST_PDN;
         `MTPD_T_SRF: start_of = ST_SRF;
         `MTPD_T_APC: start_of = ST_APC_WR;
         default:     start_of = ST_DONE;
      endcase
   endfunction : start_of

   // First enabled test at or after test k, else the end of the set
   function automatic mtpd_state_t first_test(input int k, input logic [`MTPD_EN_W-1:0] en);
      for (int j = 0; j < `MTPD_TESTS; j++) begin
         if (j >= k && test_on(j, en)) return start_of(j);
      end
      return ST_DONE;
   endfunction : first_test

   function automatic mtpd_idx_t count_of(input mtpd_state_t st);
      case (test_of(st))
         `MTPD_T_SEQ: count_of = `MTPD_SEQ_COUNT;
         `MTPD_T_INC: count_of = `MTPD_INC_COUNT;
         `MTPD_T_MSK: count_of = `MTPD_MSK_COUNT;
         `MTPD_T_ADR: count_of = `MTPD_ADR_COUNT;
         default:     count_of = `MTPD_APC_COUNT;
      endcase
   endfunction : count_of

   function automatic logic is_wr(input mtpd_state_t st);
      is_wr = (st == ST_SEQ_WR) || (st == ST_INC_WR) || (st == ST_MSK_CL) ||
              (st == ST_MSK_BY) || (st == ST_ADR_WR) || (st == ST_APC_WR);
   endfunction : is_wr

   function automatic logic is_rd(input mtpd_state_t st);
      is_rd = (st == ST_SEQ_RD) || (st == ST_INC_RD) || (st == ST_MSK_RD) ||
              (st == ST_ADR_RD) || (st == ST_APC_RD);
   endfunction : is_rd

   function automatic mtpd_addr_t addr_of(input mtpd_state_t st, input mtpd_idx_t i);
      mtpd_addr_t one;
      one = mtpd_addr_t'(1);
      case (test_of(st))
         `MTPD_T_SEQ: addr_of = {mtpd_bank_t'(i[`MTPD_SEQ_BANK_HI:`MTPD_SEQ_BANK_LO]),
                                 mtpd_row_t'(i[`MTPD_SEQ_ROW_HI:`MTPD_SEQ_ROW_LO]),
                                 mtpd_lcol_t'(i[`MTPD_SEQ_COL_HI:0])};
         `MTPD_T_INC: addr_of = mtpd_addr_t'(i) << 1;
         `MTPD_T_MSK: addr_of = mtpd_addr_t'(i);
         `MTPD_T_ADR: begin
            if (i == '0 || i > `MTPD_ADR_ZER_END) begin
               addr_of = '0;
            end else if (i <= `MTPD_ADR_ONE_END) begin
               addr_of = one << (i - 1'b1);
            end else begin
               addr_of = ~(one << (i - `MTPD_ADR_ONE_END - 1'b1));
            end
         end
         default:     addr_of = `MTPD_APC_BASE + mtpd_addr_t'(i);
      endcase
   endfunction : addr_of

   // Write data and, for the read phases, the expected word
   function automatic mtpd_data_t data_of(input mtpd_state_t st, input mtpd_idx_t i,
                                          input mtpd_data_t lf);
      case (st)
         ST_SEQ_WR, ST_SEQ_RD: data_of = lf;
         ST_MSK_CL:            data_of = '0;
         ST_MSK_BY:            data_of = `MTPD_ALL_ONES;
         ST_MSK_RD:            data_of = `MTPD_BYTE_ONES << (`MTPD_BYTE_W * i[1:0]);
         ST_APC_WR, ST_APC_RD: data_of = ~mtpd_data_t'(addr_of(st, i));
         // Address only: the address test visits address zero twice
         default:              data_of = mtpd_data_t'(addr_of(st, i));
      endcase
   endfunction : data_of

   function automatic mtpd_be_t be_of(input mtpd_state_t st, input mtpd_idx_t i);
      be_of = (st == ST_MSK_BY) ? mtpd_be_t'(`MTPD_BE_ONE << i[1:0]) : `MTPD_BE_ALL;
   endfunction : be_of

   function automatic logic [`MTPD_BE_W-1:0] byte_match(input mtpd_data_t a, input mtpd_data_t b);
      for (int k = 0; k < `MTPD_BE_W; k++) begin
         byte_match[k] = (a[k*`MTPD_BYTE_W +: `MTPD_BYTE_W] == b[k*`MTPD_BYTE_W +: `MTPD_BYTE_W]);
      end
   endfunction : byte_match

   // Enables are straps from outside; a bit moves once two stages agree
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         en_s1_r <= '0;
         en_s2_r <= '0;
         en_s3_r <= '0;
         en_r    <= '0;
      end else begin
         en_s1_r <= {low_power_option_enable, addr_pin_test_enable, byte_mask_check_enable,
                     incomplete_write_enable, seq_test_enable};
         en_s2_r <= en_s1_r;
         en_s3_r <= en_s2_r;
         en_r    <= (en_s2_r & en_s3_r) | (en_r & (en_s2_r ^ en_s3_r));
      end
   end

   assign wr_acc    = wr_req_r & local_ready;
   assign rd_acc    = rd_req_r & local_ready;
   assign chk_valid = local_rdata_valid & is_rd(state_r);

   always_comb begin
      state_nxt = state_r;
      idx_nxt   = idx_r;
      ret_nxt   = chk_valid ? ret_r + 1'b1 : ret_r;
      case (state_r)
         ST_IDLE: state_nxt = first_test(`MTPD_T_SEQ, en_r);
         ST_SEQ_WR, ST_INC_WR, ST_MSK_CL, ST_MSK_BY, ST_ADR_WR, ST_APC_WR: begin
            if (wr_acc) begin
               idx_nxt = idx_r + 1'b1;
               if (idx_r == count_of(state_r) - 1'b1) begin
                  idx_nxt   = '0;
                  state_nxt = mtpd_state_t'(state_r + 1'b1);
               end
            end
         end
         ST_SEQ_RD, ST_INC_RD, ST_MSK_RD, ST_ADR_RD, ST_APC_RD: begin
            if (rd_acc) begin
               idx_nxt = idx_r + 1'b1;
            end
            // Leave only after the last word is back, so checks never mix tests
            if (chk_valid && ret_r == count_of(state_r) - 1'b1) begin
               idx_nxt   = '0;
               ret_nxt   = '0;
               state_nxt = first_test(test_of(state_r) + 1, en_r);
            end
         end
         ST_PDN, ST_SRF: begin
            idx_nxt = idx_r + 1'b1;
            if (idx_r == hold_count) begin
               idx_nxt   = '0;
               state_nxt = first_test(test_of(state_r) + 1, en_r);
            end
         end
         ST_DONE: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   assign gen_load = (state_nxt == ST_SEQ_WR) && (state_r != ST_SEQ_WR);
   assign gen_step = wr_acc && (state_r == ST_SEQ_WR);
   assign chk_load = (state_nxt == ST_SEQ_RD) && (state_r != ST_SEQ_RD);
   assign chk_step = chk_valid && (state_r == ST_SEQ_RD);

   mtpd_lfsr u_gen (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .load      (gen_load),
      .step      (gen_step),
      .value     (gen_q),
      .value_nxt (gen_nxt)
   );

   mtpd_lfsr u_chk (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .load      (chk_load),
      .step      (chk_step),
      .value     (chk_q),
      .value_nxt ()
   );

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         idx_r   <= '0;
         ret_r   <= '0;
      end else begin
         state_r <= state_nxt;
         idx_r   <= idx_nxt;
         ret_r   <= ret_nxt;
      end
   end

   // Request word follows the index, so it cannot move while unaccepted
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_r    <= '0;
         wr_req_r <= 1'b0;
         rd_req_r <= 1'b0;
      end else begin
         req_r.addr <= addr_of(state_nxt, idx_nxt);
         req_r.data <= data_of(state_nxt, idx_nxt, gen_nxt);
         req_r.be   <= be_of(state_nxt, idx_nxt);
         wr_req_r   <= is_wr(state_nxt);
         rd_req_r   <= is_rd(state_nxt) && (idx_nxt < count_of(state_nxt));
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pdn_r    <= 1'b0;
         srf_r    <= 1'b0;
         apc_r    <= 1'b0;
         status_r <= '0;
         done_r   <= 1'b0;
      end else begin
         pdn_r    <= (state_nxt == ST_PDN);
         srf_r    <= (state_nxt == ST_SRF);
         apc_r    <= (test_of(state_nxt) == `MTPD_T_APC);
         status_r <= '0;
         if (test_of(state_nxt) < `MTPD_TESTS) begin
            status_r[test_of(state_nxt)] <= 1'b1;
         end
         done_r   <= (state_nxt == ST_DONE);
      end
   end

   assign exp_data = data_of(state_r, ret_r, chk_q);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pnf_r      <= 1'b1;
         pnf_byte_r <= '1;
      end else if (chk_valid) begin
         pnf_byte_r <= byte_match(local_rdata, exp_data);
         if (local_rdata != exp_data) begin
            pnf_r <= 1'b0;
         end
      end
   end

   assign local_write_req      = wr_acc;
   assign local_read_req       = rd_acc;
   assign local_address        = req_r.addr;
   assign local_wdata          = req_r.data;
   assign request_byte_enables = req_r.be;
   assign local_size           = `MTPD_SIZE_ONE;
   assign local_powerdn_req    = pdn_r;
   assign local_self_rfsh_req  = srf_r;
   assign local_autopch_req    = apc_r;
   assign pnf                  = pnf_r;
   assign pnf_per_byte         = pnf_byte_r;
   assign test_status          = status_r;
   assign test_complete        = done_r;

   // Checks on the driven side
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   logic [`MTPD_IDX_W:0] pdn_len_r;
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pdn_len_r <= '0;
      end else begin
         pdn_len_r <= pdn_r ? pdn_len_r + 1'b1 : '0;
      end
   end

   sequence s_set_done;
      test_complete ##1 !test_complete;
   endsequence
   sequence s_restart;
      (state_r == ST_IDLE) ##1 (state_r != ST_IDLE && state_r != ST_DONE);
   endsequence

   a_loop_restart: assert property (test_complete |-> s_set_done ##0 s_restart)
      else $error("test set did not restart after completion");
   a_status_onehot: assert property ($onehot0(test_status) &&
      ((state_r == ST_IDLE || state_r == ST_DONE) -> test_status == '0))
      else $error("test status not one-hot");
   a_req_ready: assert property ((local_write_req || local_read_req) |->
      local_ready && !(local_write_req && local_read_req))
      else $error("request shown without ready");
   a_req_held: assert property ((wr_req_r || rd_req_r) && !local_ready |=>
      $stable(local_address) && $stable(local_wdata) && (wr_req_r || rd_req_r))
      else $error("pending request changed before acceptance");
   a_pnf_sticky: assert property (!pnf |=> !pnf)
      else $error("pass flag recovered after failure");
   a_pnf_drop: assert property (chk_valid && local_rdata != exp_data |=> !pnf)
      else $error("mismatch did not clear pass flag");
   a_byte_flags: assert property (chk_valid |=>
      pnf_per_byte == byte_match($past(local_rdata), $past(exp_data)))
      else $error("per-byte flags do not follow checked word");
   a_seq_skip: assert property ($rose(test_status[`MTPD_T_SEQ]) |-> en_r[`MTPD_EN_SEQ])
      else $error("sequential test ran while disabled");
   a_inc_skip: assert property ($rose(test_status[`MTPD_T_INC]) |-> en_r[`MTPD_EN_INC])
      else $error("incomplete write test ran while disabled");
   a_mask_skip: assert property ($rose(test_status[`MTPD_T_MSK]) |-> en_r[`MTPD_EN_MSK])
      else $error("byte mask test ran while disabled");
   a_addr_skip: assert property ($rose(test_status[`MTPD_T_ADR]) |-> en_r[`MTPD_EN_ADR])
      else $error("address pin test ran while disabled");
   a_lp_skip: assert property ($rose(local_powerdn_req || local_self_rfsh_req) |->
      en_r[`MTPD_EN_LP])
      else $error("low-power test ran without the option");
   a_pdn_hold: assert property ($fell(local_powerdn_req) |->
      pdn_len_r == {1'b0, hold_count} + 1'b1 ##0 local_self_rfsh_req || !en_r[`MTPD_EN_LP])
      else $error("power-down not held for the hold count");
   a_mask_byte: assert property (local_write_req && state_r == ST_MSK_BY |->
      $onehot(request_byte_enables))
      else $error("byte mask write without one byte enable");
   a_seq_reload: assert property (chk_load |=> chk_q == `MTPD_LFSR_SEED)
      else $error("check generator not reloaded for readback");
endmodule : mtpd_driver

// ==== bench/mtpd_ctrl_model.sv ====
// Behavioural controller local port: memory, stalls, in-order returns
`timescale 1ns/1ns
module mtpd_ctrl_model
   import mtpd_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       slow,
   input  wire logic       corrupt,
   input  wire logic       wr_req,
   input  wire logic       rd_req,
   input  wire mtpd_addr_t addr,
   input  wire mtpd_data_t wdata,
   input  wire mtpd_be_t   be,
   output logic            ready,
   output mtpd_data_t      rdata,
   output logic            rvalid
);
   mtpd_data_t mem [mtpd_addr_t];
   mtpd_data_t q [$];
   always @(posedge core_clk) begin
      ready <= slow ? 1'($urandom % 2) : 1'b1;
      if (wr_req) begin
         if (!mem.exists(addr)) mem[addr] = '0;
         for (int k = 0; k < 4; k++)
            if (be[k]) mem[addr][8*k +: 8] = wdata[8*k +: 8];
      end
      if (rd_req) q.push_back(mem.exists(addr) ? mem[addr] : '0);
      if (q.size() > 0 && $urandom % 3 == 0) begin
         rdata <= q.pop_front() ^ {31'h0, corrupt};
         rvalid <= 1'b1;
      end else begin
         // Idle bus toggles so stale data never looks valid
         rdata <= ~rdata;
         rvalid <= 1'b0;
      end
   end
endmodule : mtpd_ctrl_model

// ==== bench/tb_mtpd_driver.sv ====
// Self-checking bench for the memory test pattern driver
`timescale 1ns/1ns
module tb_mtpd_driver
   import mtpd_pkg::*;
   ;
   logic       core_clk, sys_rst, slow, corrupt, pnf, cmp, wr, rd, rv, rdy, pdn, pcmp;
   logic       srf, apc;
   logic [1:0] sz;
   logic [4:0] en;
   logic [15:0] hold;
   logic [6:0] st, seen;
   mtpd_addr_t addr;
   mtpd_data_t wd, rdat;
   mtpd_be_t   be, pbb;
   int         fails, n_tests, pcnt, scnt;

   mtpd_driver mtpd_driver_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .seq_test_enable(en[0]), .incomplete_write_enable(en[1]),
      .byte_mask_check_enable(en[2]), .addr_pin_test_enable(en[3]),
      .low_power_option_enable(en[4]), .hold_count(hold), .local_ready(rdy),
      .local_rdata(rdat), .local_rdata_valid(rv), .local_write_req(wr),
      .local_read_req(rd), .local_address(addr), .local_wdata(wd),
      .request_byte_enables(be), .local_size(sz), .local_powerdn_req(pdn),
      .local_self_rfsh_req(srf), .local_autopch_req(apc), .pnf(pnf),
      .pnf_per_byte(pbb), .test_status(st), .test_complete(cmp));
   mtpd_ctrl_model mtpd_ctrl_model_i (.core_clk(core_clk), .slow(slow),
      .corrupt(corrupt), .wr_req(wr), .rd_req(rd), .addr(addr), .wdata(wd),
      .be(be), .ready(rdy), .rdata(rdat), .rvalid(rv));

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         fails++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask : check

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // Waits one test set; enable changes need a spare set to pass the synchroniser
   task automatic run_set(input bit chk, input logic [6:0] xst, input logic xp,
                          input mtpd_be_t xpb);
      int i;
      @(posedge core_clk);
      #1;
      for (i = 0; i < 20000 && cmp !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      if (i == 20000) begin
         check(1'b0, "no completion");
         summarize();
      end else if (chk) begin
         check(seen === xst, "tests run");
         check(pnf === xp, "pass flag");
         check(pbb === xpb, "byte flags");
      end
   endtask : run_set

   always @(posedge core_clk) begin
      // Cleared at each completion so a set is judged on its own
      seen <= (cmp || sys_rst) ? 7'h0 : (seen | st);
      pcmp <= cmp;
      pcnt <= pdn ? pcnt + 1 : 0;
      scnt <= srf ? scnt + 1 : 0;
      if (!sys_rst) begin
         if (!srf && scnt != 0) check(scnt == hold + 1, "self-refresh hold");
         check(apc === st[6], "auto-precharge request");
         if (wr || rd) check(sz === 2'h1, "request size");
         check((st & (st - 7'h1)) == 7'h0, "status not one-hot");
         check(!(cmp && pcmp), "complete pulse too long");
         if (!pdn && pcnt != 0) check(pcnt == hold + 1, "power-down hold");
      end
   end

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   initial begin
      sys_rst = 1'b1;
      en = '0;
      hold = 16'h4;
      slow = 1'b0;
      corrupt = 1'b0;
      void'($urandom(19));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      en <= 5'h1f;
      run_set(0, 7'h0, 1'b1, 4'hf);
      run_set(1, 7'h7f, 1'b1, 4'hf);
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         en <= (k == 0) ? 5'h0 : 5'($urandom);
         hold <= 16'($urandom % 6);
         slow <= 1'b1;
         run_set(0, 7'h0, 1'b1, 4'hf);
         run_set(1, {1'b1, en[4], en[4], en[3:0]}, 1'b1, 4'hf);
      end
      @(posedge core_clk);
      en <= 5'h1f;
      corrupt <= 1'b1;
      run_set(0, 7'h0, 1'b0, 4'he);
      run_set(1, 7'h7f, 1'b0, 4'he);
      corrupt <= 1'b0;
      run_set(0, 7'h0, 1'b0, 4'hf);
      run_set(1, 7'h7f, 1'b0, 4'hf);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      @(posedge core_clk);
      #1;
      check(pnf === 1'b1 && st === 7'h0, "reset state");
      summarize();
   end
endmodule : tb_mtpd_driver
